// >>> rtl/vidc_top.sv
// Vectored interrupt request, acknowledge and priority chain logic.
// Assumes host pins are asynchronous and software uses AXI4-Lite on aclk.
//
// Overview of operation
// R1: After reset the block is in plain mode and enters chain mode only on the mode-select command.
// R2: A pending request drives irq_request_n low.
// R3: The host answers a request with an acknowledge.
// R4: On acknowledge the block drives its vector register onto the data bus.
// R5: The host reads the vector during the acknowledge and branches.
// R6: Chain-enable pins act only in chain mode and are active high.
// R7: With chain enable high, sources not masked may request.
// R8: With chain enable low, no request reaches the host.
// R9: Chain-enable out is high only with input high, nothing pending and nothing in service.
// R10: After service chain-enable out stays low until the clear-in-service command.
// R11: Software ends each service routine with the clear-in-service command.
// R12: A blocked device stays silent until its upstream chain output returns high.
// R13: An asserted acknowledge means the next cycle is the vector cycle.
// R14: The in-service flag sets on vector delivery in chain mode only and clears on command or reset.
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`include "vidc_defs.svh"
module vidc_top (
    // Clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]      s_awaddr,
    input  wire logic            s_awvalid,
    output logic                 s_awready,
    input  wire logic [31:0]     s_wdata,
    input  wire logic [3:0]      s_wstrb,
    input  wire logic            s_wvalid,
    output logic                 s_wready,
    output logic [1:0]           s_bresp,
    output logic                 s_bvalid,
    input  wire logic            s_bready,
    input  wire logic [7:0]      s_araddr,
    input  wire logic            s_arvalid,
    output logic                 s_arready,
    output logic [31:0]          s_rdata,
    output logic [1:0]           s_rresp,
    output logic                 s_rvalid,
    input  wire logic            s_rready,
    // Interrupt sources and host pins
    input  wire logic [7:0]      src_req,
    input  vidc_pkg::vidc_host_in_t  host_in,
    output vidc_pkg::vidc_host_out_t host_out,
    // Block interrupt
    output logic                 irq
);
    import vidc_pkg::*;

    logic        wr_en, rd_en, wr_err, rd_err;
    logic [7:0]  wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0]  wr_strb;
    logic [1:0]  pins_s;

    vidc_axil u_axil (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .s_awaddr  (s_awaddr),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wdata   (s_wdata),
        .s_wstrb   (s_wstrb),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .s_araddr  (s_araddr),
        .s_arvalid (s_arvalid),
        .s_arready (s_arready),
        .s_rdata   (s_rdata),
        .s_rresp   (s_rresp),
        .s_rvalid  (s_rvalid),
        .s_rready  (s_rready),
        .wr_en     (wr_en),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .wr_strb   (wr_strb),
        .wr_err    (wr_err),
        .rd_en     (rd_en),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data),
        .rd_err    (rd_err)
    );

    // Pin synchroniser; ack idles high, chain input idles low
    vidc_sync #(.W(2), .INIT(2'b10)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({host_in.ack_input_n, host_in.chain_enable_in}),
        .q       (pins_s)
    );

    logic ack_s, cei_s;
    assign ack_s = ~pins_s[1];
    assign cei_s = pins_s[0];

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
        is_addr = (a == ref_a);
    endfunction

    // Software state
    logic        chain_mode_reg, chain_mode_next;
    logic [7:0]  vector_holding_register, vector_next;
    logic [7:0]  source_mask_register, mask_next;
    logic [2:0]  ev_st_reg, ev_st_next, ev_en_reg, ev_en_next;
    logic        clear_in_service_command;
    logic [2:0]  ev_clr;
    // Chain state
    vidc_state_t state_reg, state_next;
    logic        in_service_reg, in_service_next;
    logic        ack_prev_reg, ack_prev_next;
    logic        cei_prev_reg;
    logic        irq_n_reg, irq_n_next, ceo_reg, ceo_next;
    logic [7:0]  data_reg, data_next;
    logic        oe_reg, oe_next, irq_reg, irq_next;
    logic        pending, gate_open, ack_rise;
    logic [2:0]  ev_set;

    assign pending   = |(src_req & source_mask_register); // R7
    assign gate_open = ~chain_mode_reg | cei_s; // R6 R8 R12
    assign ack_rise  = ack_s & ~ack_prev_reg;

    // Register writes and commands
    always_comb begin
        chain_mode_next = chain_mode_reg;
        vector_next     = vector_holding_register;
        mask_next       = source_mask_register;
        ev_en_next      = ev_en_reg;
        ev_clr          = 3'h0;
        clear_in_service_command = 1'b0;
        wr_err          = 1'b0;
        if (wr_en) begin
            if (is_addr(wr_addr, `VIDC_ADDR_CTRL)) begin
                if (wr_strb[0] && wr_data[`VIDC_CMD_CHAIN]) begin
                    chain_mode_next = 1'b1; // R1
                end else if (wr_strb[0] && wr_data[`VIDC_CMD_PLAIN]) begin
                    chain_mode_next = 1'b0;
                end
                clear_in_service_command = wr_strb[0] & wr_data[`VIDC_CMD_CLR_IUS]; // R10
            end else if (is_addr(wr_addr, `VIDC_ADDR_VECTOR)) begin
                if (wr_strb[0]) vector_next = wr_data[7:0];
            end else if (is_addr(wr_addr, `VIDC_ADDR_MASK)) begin
                if (wr_strb[0]) mask_next = wr_data[7:0];
            end else if (is_addr(wr_addr, `VIDC_ADDR_IRQ_EN)) begin
                if (wr_strb[0]) ev_en_next = wr_data[2:0];
            end else if (is_addr(wr_addr, `VIDC_ADDR_IRQ_CLR)) begin
                if (wr_strb[0]) ev_clr = wr_data[2:0];
            end else if (!is_addr(wr_addr, `VIDC_ADDR_SOURCES) && !is_addr(wr_addr, `VIDC_ADDR_STATUS)
                         && !is_addr(wr_addr, `VIDC_ADDR_IRQ_ST)) begin
                wr_err = 1'b1;
            end
        end
        if (!aresetn) begin
            chain_mode_next = 1'b0; // R1
            vector_next     = `VIDC_VECTOR_RST;
            mask_next       = `VIDC_MASK_RST;
            ev_en_next      = 3'h0;
        end
    end

    // Register reads
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (is_addr(rd_addr, `VIDC_ADDR_CTRL)) begin
            rd_data = {31'h0, chain_mode_reg};
        end else if (is_addr(rd_addr, `VIDC_ADDR_VECTOR)) begin
            rd_data = {24'h0, vector_holding_register};
        end else if (is_addr(rd_addr, `VIDC_ADDR_MASK)) begin
            rd_data = {24'h0, source_mask_register};
        end else if (is_addr(rd_addr, `VIDC_ADDR_SOURCES)) begin
            rd_data = {24'h0, src_req};
        end else if (is_addr(rd_addr, `VIDC_ADDR_STATUS)) begin
            rd_data = {24'h0, state_reg, cei_s, ceo_reg, ~irq_n_reg, in_service_reg};
        end else if (is_addr(rd_addr, `VIDC_ADDR_IRQ_ST)) begin
            rd_data = {29'h0, ev_st_reg};
        end else if (is_addr(rd_addr, `VIDC_ADDR_IRQ_EN)) begin
            rd_data = {29'h0, ev_en_reg};
        end else if (!is_addr(rd_addr, `VIDC_ADDR_IRQ_CLR)) begin
            rd_err = 1'b1;
        end
    end

    // Chain and acknowledge sequencer
    always_comb begin
        state_next      = state_reg;
        in_service_next = in_service_reg;
        ack_prev_next   = ack_s;
        data_next       = data_reg;
        oe_next         = 1'b0;
        ev_set          = 3'h0;
        case (state_reg)
            VIDC_IDLE: begin
                if (pending && gate_open && !in_service_reg) state_next = VIDC_REQUEST; // R2 R8
            end
            VIDC_REQUEST: begin
                if (ack_rise) begin
                    state_next = VIDC_VECTOR; // R13
                    data_next  = vector_holding_register; // R4
                    oe_next    = 1'b1;
                    ev_set[`VIDC_EV_ACK] = 1'b1;
                end else if (!pending || !gate_open) begin
                    state_next = VIDC_IDLE; // R12
                end
            end
            VIDC_VECTOR: begin
                if (ack_s) begin
                    oe_next = 1'b1; // R4
                end else begin
                    state_next      = chain_mode_reg ? VIDC_SERVICE : VIDC_IDLE;
                    in_service_next = chain_mode_reg; // R14
                end
            end
            VIDC_SERVICE: begin
                if (!in_service_reg) state_next = VIDC_IDLE;
            end
            default: state_next = VIDC_IDLE;
        endcase
        if (clear_in_service_command) begin
            in_service_next = 1'b0; // R14
            ev_set[`VIDC_EV_CLR] = in_service_reg;
        end
        if (state_reg == VIDC_VECTOR && !ack_s && chain_mode_reg) in_service_next = 1'b1;
        ev_set[`VIDC_EV_BLOCKED] = chain_mode_reg & cei_prev_reg & ~cei_s;
        if (!aresetn) begin
            state_next      = VIDC_IDLE;
            in_service_next = 1'b0;
            ack_prev_next   = 1'b0;
            data_next       = 8'h00;
            oe_next         = 1'b0;
        end
    end

    // Pin outputs and event flags; set wins over clear
    always_comb begin
        irq_n_next = ~(state_reg == VIDC_REQUEST && pending && gate_open); // R2 R7 R8
        ceo_next   = chain_mode_reg & cei_s & ~pending & ~in_service_reg
                     & (state_reg == VIDC_IDLE); // R6 R9 R10
        ev_st_next = (ev_st_reg & ~ev_clr) | ev_set;
        irq_next   = |(ev_st_reg & ev_en_reg);
        if (!aresetn) begin
            irq_n_next = 1'b1;
            ceo_next   = 1'b0;
            ev_st_next = 3'h0;
            irq_next   = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        chain_mode_reg          <= chain_mode_next;
        vector_holding_register <= vector_next;
        source_mask_register    <= mask_next;
        ev_en_reg               <= ev_en_next;
        ev_st_reg               <= ev_st_next;
        state_reg               <= state_next;
        in_service_reg          <= in_service_next;
        ack_prev_reg            <= ack_prev_next;
        cei_prev_reg            <= aresetn ? cei_s : 1'b0;
        irq_n_reg               <= irq_n_next;
        ceo_reg                 <= ceo_next;
        data_reg                <= data_next;
        oe_reg                  <= oe_next;
        irq_reg                 <= irq_next;
    end

    assign host_out.irq_request_n    = irq_n_reg;
    assign host_out.chain_enable_out = ceo_reg;
    assign host_out.data_out         = data_reg;
    assign host_out.data_oe          = oe_reg;
    assign irq                       = irq_reg;

    // Checks
    chk_reset_plain: assert property (@(posedge aclk) !aresetn |=> !chain_mode_reg) // R1
        else $error("mode not plain after reset");
    chk_req_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == VIDC_REQUEST && pending && gate_open) |=> !host_out.irq_request_n) // R2
        else $error("request not driven");
    chk_vector_out: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == VIDC_REQUEST && ack_rise) |=> (host_out.data_oe
        && host_out.data_out == $past(vector_holding_register))) // R4 R13
        else $error("vector missing on acknowledge");
    chk_plain_ceo: assert property (@(posedge aclk) disable iff (!aresetn)
        !chain_mode_reg |=> !host_out.chain_enable_out) // R6
        else $error("chain out active in plain mode");
    chk_mask_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_reg == VIDC_REQUEST && !pending) |=> host_out.irq_request_n) // R7
        else $error("masked source requested");
    chk_block_all: assert property (@(posedge aclk) disable iff (!aresetn)
        (chain_mode_reg && !cei_s) |=> host_out.irq_request_n) // R8 R12
        else $error("request while chain input low");
    chk_ceo_cond: assert property (@(posedge aclk) disable iff (!aresetn)
        host_out.chain_enable_out |-> ($past(cei_s) && !$past(pending) && !$past(in_service_reg))) // R9
        else $error("chain out high wrongly");
    chk_ius_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (in_service_reg && !clear_in_service_command) |=> in_service_reg ##1 !host_out.chain_enable_out) // R10 R14
        else $error("in service dropped without command");
    cov_ack: cover property (@(posedge aclk) disable iff (!aresetn) state_reg == VIDC_VECTOR);
    cov_service: cover property (@(posedge aclk) disable iff (!aresetn) in_service_reg ##1 !in_service_reg);
    cov_blocked: cover property (@(posedge aclk) disable iff (!aresetn) ev_set[`VIDC_EV_BLOCKED]);
endmodule

// >>> rtl/vidc_defs.svh
// Constants of the vectored interrupt chain block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef VIDC_DEFS_SVH
`define VIDC_DEFS_SVH

`define VIDC_ADDR_CTRL    8'h00
`define VIDC_ADDR_VECTOR  8'h04
`define VIDC_ADDR_MASK    8'h08
`define VIDC_ADDR_SOURCES 8'h0c
`define VIDC_ADDR_STATUS  8'h10
`define VIDC_ADDR_IRQ_ST  8'h14
`define VIDC_ADDR_IRQ_EN  8'h18
`define VIDC_ADDR_IRQ_CLR 8'h1c

`define VIDC_CMD_CHAIN    0
`define VIDC_CMD_PLAIN    1
`define VIDC_CMD_CLR_IUS  2

`define VIDC_EV_ACK       0
`define VIDC_EV_CLR       1
`define VIDC_EV_BLOCKED   2

`define VIDC_RESP_OKAY    2'b00
`define VIDC_RESP_SLVERR  2'b10
`define VIDC_VECTOR_RST   8'h0f
`define VIDC_MASK_RST     8'h00

`endif

// >>> rtl/vidc_pkg.sv
// Types of the vectored interrupt chain block.
// Assumes nothing beyond the defines header.
package vidc_pkg;
    typedef struct packed {
        logic       ack_input_n;
        logic       chain_enable_in;
    } vidc_host_in_t;

    typedef struct packed {
        logic       irq_request_n;
        logic       chain_enable_out;
        logic [7:0] data_out;
        logic       data_oe;
    } vidc_host_out_t;

    typedef enum logic [3:0] {
        VIDC_IDLE    = 4'b0001,
        VIDC_REQUEST = 4'b0010,
        VIDC_VECTOR  = 4'b0100,
        VIDC_SERVICE = 4'b1000
    } vidc_state_t;
endpackage

// >>> rtl/vidc_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes a single clock domain on aclk.
`timescale 1ns/1ps
module vidc_sync #(
    parameter int W = 2,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_next;

    always_comb begin
        meta_next = aresetn ? d : INIT;
        q_next    = aresetn ? meta_reg : INIT;
    end

    always_ff @(posedge aclk) begin
        meta_reg <= meta_next;
        q        <= q_next;
    end
endmodule

// >>> rtl/vidc_axil.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes a single clock domain; register decode is outside.
`timescale 1ns/1ps
module vidc_axil (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // Register side
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_err,
    output logic             rd_en,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_err
);
    logic        aw_reg, aw_next, w_reg, w_next, b_reg, b_next, r_reg, r_next;
    logic [7:0]  awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
    logic [3:0]  ws_reg, ws_next;
    logic [1:0]  br_reg, br_next, rr_reg, rr_next;

    assign s_awready = ~aw_reg & ~b_reg;
    assign s_wready  = ~w_reg & ~b_reg;
    assign s_arready = ~r_reg;
    assign s_bvalid  = b_reg;
    assign s_bresp   = br_reg;
    assign s_rvalid  = r_reg;
    assign s_rresp   = rr_reg;
    assign s_rdata   = rd_reg;
    assign wr_en     = aw_reg & w_reg & ~b_reg;
    assign wr_addr   = awa_reg;
    assign wr_data   = wd_reg;
    assign wr_strb   = ws_reg;
    assign rd_en     = s_arvalid & ~r_reg;
    assign rd_addr   = s_araddr;

    always_comb begin
        aw_next = aw_reg; w_next = w_reg; b_next = b_reg; r_next = r_reg;
        awa_next = awa_reg; wd_next = wd_reg; ws_next = ws_reg;
        br_next = br_reg; rr_next = rr_reg; rd_next = rd_reg;
        if (s_awvalid && s_awready) begin
            aw_next  = 1'b1;
            awa_next = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            w_next  = 1'b1;
            wd_next = s_wdata;
            ws_next = s_wstrb;
        end
        if (wr_en) begin
            aw_next = 1'b0;
            w_next  = 1'b0;
            b_next  = 1'b1;
            br_next = wr_err ? `VIDC_RESP_SLVERR : `VIDC_RESP_OKAY;
        end else if (b_reg && s_bready) begin
            b_next = 1'b0;
        end
        if (rd_en) begin
            r_next  = 1'b1;
            rd_next = rd_data;
            rr_next = rd_err ? `VIDC_RESP_SLVERR : `VIDC_RESP_OKAY;
        end else if (r_reg && s_rready) begin
            r_next = 1'b0;
        end
        if (!aresetn) begin
            aw_next = 1'b0; w_next = 1'b0; b_next = 1'b0; r_next = 1'b0;
            awa_next = 8'h00; wd_next = 32'h0000_0000; ws_next = 4'h0;
            br_next = 2'h0; rr_next = 2'h0; rd_next = 32'h0000_0000;
        end
    end

    always_ff @(posedge aclk) begin
        aw_reg <= aw_next; w_reg <= w_next; b_reg <= b_next; r_reg <= r_next;
        awa_reg <= awa_next; wd_reg <= wd_next; ws_reg <= ws_next;
        br_reg <= br_next; rr_reg <= rr_next; rd_reg <= rd_next;
    end
endmodule

// >>> test/vidc_host_model.sv
// Host processor model: acknowledges requests and reads the vector byte.
// Assumes device pins on aclk; bench sets delay, enable and stray pulses.
`timescale 1ns/1ps
module vidc_host_model (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Device pins
    input  wire logic       irq_request_n,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output logic            ack_input_n,
    // Bench control
    input  wire logic       ack_en,
    input  wire logic       spur_ack,
    input  wire logic [3:0] ack_dly,
    output logic [7:0]      vec_seen,
    output int              vec_cnt
);
    logic ack_q;
    assign ack_input_n = ack_q & ~spur_ack;
    initial begin
        ack_q = 1'b1;
        vec_seen = 8'h00;
        vec_cnt = 0;
        forever begin
            @(posedge aclk);
            if (aresetn && ack_en && irq_request_n === 1'b0) begin
                repeat (ack_dly) @(posedge aclk);
                ack_q <= 1'b0;
                for (int n = 0; n < 40 && data_oe !== 1'b1; n++) @(posedge aclk);
                if (data_oe === 1'b1) begin
                    vec_seen <= data_out;
                    vec_cnt <= vec_cnt + 1;
                end
                @(posedge aclk);
                ack_q <= 1'b1;
                repeat (8) @(posedge aclk);
            end
        end
    end
endmodule

// >>> test/vidc_top_tb.sv
// Bench for the vectored interrupt chain block: AXI4-Lite tasks and pin checks.
// Assumes the rtl files and the host model are compiled first.
`timescale 1ns/1ps
`include "vidc_defs.svh"
`define CHK(nm, ex, got) \
    begin \
        tests_run++; \
        if ((got) !== (ex)) begin \
            error_cnt++; \
            $display("ERROR %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module vidc_top_tb;
    import vidc_pkg::*;
    logic           aclk, aresetn, aw_v, aw_r, w_v, w_r, b_v, b_y, ar_v, ar_r, r_v, r_y;
    logic           cei, ack_n, ack_en, spur, irq, bad;
    logic [7:0]     aw_a, ar_a, src, vec;
    logic [31:0]    w_d, r_d, rdat;
    logic [3:0]     w_s, dly;
    logic [1:0]     b_rs, r_rs, resp;
    int             error_cnt = 0, tests_run = 0, vcnt, cyc = 0, c;
    vidc_host_in_t  host_in;
    vidc_host_out_t host_out;
    assign host_in = '{ack_input_n: ack_n, chain_enable_in: cei};
    vidc_top u_vidc_top (
        .aclk(aclk), .aresetn(aresetn), .s_awaddr(aw_a), .s_awvalid(aw_v), .s_awready(aw_r),
        .s_wdata(w_d), .s_wstrb(w_s), .s_wvalid(w_v), .s_wready(w_r), .s_bresp(b_rs),
        .s_bvalid(b_v), .s_bready(b_y), .s_araddr(ar_a), .s_arvalid(ar_v), .s_arready(ar_r),
        .s_rdata(r_d), .s_rresp(r_rs), .s_rvalid(r_v), .s_rready(r_y), .src_req(src),
        .host_in(host_in), .host_out(host_out), .irq(irq)
    );
    vidc_host_model u_vidc_host_model (
        .aclk(aclk), .aresetn(aresetn), .irq_request_n(host_out.irq_request_n),
        .data_out(host_out.data_out), .data_oe(host_out.data_oe), .ack_input_n(ack_n),
        .ack_en(ack_en), .spur_ack(spur), .ack_dly(dly), .vec_seen(vec), .vec_cnt(vcnt)
    );
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("ERROR timeout exp %0d got %0d", 20000, cyc);
            finish_test();
        end
    end
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_y <= 1'b1;
        do begin
            @(posedge aclk);
            if (aw_r)
                aw_v <= 1'b0;
            if (w_r)
                w_v <= 1'b0;
        end while (b_v !== 1'b1);
        resp = b_rs;
        b_y <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        ar_a <= a;
        ar_v <= 1'b1;
        r_y <= 1'b1;
        do begin
            @(posedge aclk);
            if (ar_r)
                ar_v <= 1'b0;
        end while (r_v !== 1'b1);
        rdat = r_d;
        resp = r_rs;
        r_y <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        axi_rd(a);
        `CHK("rresp", `VIDC_RESP_OKAY, resp)
        `CHK(nm, e, rdat & m)
    endtask
    task automatic wait_irqn(input logic lvl);
        for (int n = 0; n < 60 && host_out.irq_request_n !== lvl; n++) @(posedge aclk);
        `CHK("irq_request_n", lvl, host_out.irq_request_n)
    endtask
    task automatic wait_vec(input int c0);
        for (int n = 0; n < 80 && vcnt == c0; n++) @(posedge aclk);
        `CHK("vector count", c0 + 1, vcnt)
    endtask
    task automatic quiet(input int n);
        bad = 1'b0;
        repeat (n) begin
            @(posedge aclk);
            if (host_out.irq_request_n !== 1'b1)
                bad = 1'b1;
        end
    endtask
    initial begin
        {aw_v, w_v, b_y, ar_v, r_y, cei, ack_en, spur, aresetn} = '0;
        {aw_a, ar_a, src, w_d} = '0;
        w_s = 4'hf;
        dly = 4'h1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk("mode", `VIDC_ADDR_CTRL, 32'h1, 32'h0);
        rd_chk("vector", `VIDC_ADDR_VECTOR, 32'hff, `VIDC_VECTOR_RST);
        rd_chk("mask", `VIDC_ADDR_MASK, 32'hff, `VIDC_MASK_RST);
        axi_rd(8'h40);
        `CHK("unmapped rresp", `VIDC_RESP_SLVERR, resp)
        axi_wr(8'h40, 32'h0);
        `CHK("unmapped bresp", `VIDC_RESP_SLVERR, resp)
        `CHK("idle request", 1'b1, host_out.irq_request_n)
        spur <= 1'b1;
        repeat (8) @(posedge aclk);
        `CHK("stray ack oe", 1'b0, host_out.data_oe)
        spur <= 1'b0;
        $display("Test reset done");
        axi_wr(`VIDC_ADDR_MASK, 32'h03);
        axi_wr(`VIDC_ADDR_VECTOR, 32'h5a);
        ack_en <= 1'b1;
        c = vcnt;
        src <= 8'h01;
        wait_irqn(1'b0);
        wait_vec(c);
        `CHK("plain vector", 8'h5a, vec)
        src <= 8'h00;
        repeat (10) @(posedge aclk);
        rd_chk("plain service", `VIDC_ADDR_STATUS, 32'h1, 32'h0);
        $display("Test plain done");
        axi_wr(`VIDC_ADDR_IRQ_CLR, 32'h7);
        axi_wr(`VIDC_ADDR_IRQ_EN, 32'h7);
        cei <= 1'b1;
        axi_wr(`VIDC_ADDR_CTRL, 32'h1 << `VIDC_CMD_CHAIN);
        rd_chk("mode", `VIDC_ADDR_CTRL, 32'h1, 32'h1);
        src <= 8'h04;
        quiet(20);
        `CHK("masked source", 1'b0, bad)
        `CHK("chain out idle", 1'b1, host_out.chain_enable_out)
        c = vcnt;
        dly <= 4'h8;
        src <= 8'h06;
        wait_irqn(1'b0);
        `CHK("chain out pending", 1'b0, host_out.chain_enable_out)
        wait_vec(c);
        `CHK("chain vector", 8'h5a, vec)
        src <= 8'h04;
        repeat (10) @(posedge aclk);
        `CHK("chain out served", 1'b0, host_out.chain_enable_out)
        rd_chk("in service", `VIDC_ADDR_STATUS, 32'h1, 32'h1);
        `CHK("irq", 1'b1, irq)
        axi_wr(`VIDC_ADDR_IRQ_EN, 32'h0);
        `CHK("irq masked", 1'b0, irq)
        axi_wr(`VIDC_ADDR_IRQ_EN, 32'h7);
        axi_wr(`VIDC_ADDR_IRQ_CLR, 32'h1);
        `CHK("irq cleared", 1'b0, irq)
        axi_wr(`VIDC_ADDR_CTRL, 32'h1 << `VIDC_CMD_CLR_IUS);
        repeat (4) @(posedge aclk);
        `CHK("chain out freed", 1'b1, host_out.chain_enable_out)
        rd_chk("events", `VIDC_ADDR_IRQ_ST, 32'h7, 32'h2);
        $display("Test chain done");
        axi_wr(`VIDC_ADDR_IRQ_CLR, 32'h7);
        cei <= 1'b0;
        repeat (4) @(posedge aclk);
        src <= 8'h06;
        quiet(20);
        `CHK("blocked request", 1'b0, bad)
        `CHK("chain out blocked", 1'b0, host_out.chain_enable_out)
        rd_chk("blocked event", `VIDC_ADDR_IRQ_ST, 32'h4, 32'h4);
        c = vcnt;
        cei <= 1'b1;
        wait_irqn(1'b0);
        wait_vec(c);
        src <= 8'h00;
        repeat (8) @(posedge aclk);
        axi_wr(`VIDC_ADDR_CTRL, 32'h1 << `VIDC_CMD_CLR_IUS);
        rd_chk("service cleared", `VIDC_ADDR_STATUS, 32'h1, 32'h0);
        $display("Test blocked done");
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk("mode", `VIDC_ADDR_CTRL, 32'h1, 32'h0);
        `CHK("plain chain out", 1'b0, host_out.chain_enable_out)
        $display("Test rereset done");
        finish_test();
    end
endmodule
